/* common/region_boundary_command_regs.svh */
// register map, command encoding and reset values of the region boundary allocator
// assumes a 32-bit apb slave with byte addresses, one aligned word per register
`ifndef REGION_BOUNDARY_REGS_SVH
`define REGION_BOUNDARY_REGS_SVH

`define OFS_CMD_HDR      8'h00
`define OFS_PIPE_CTRL    8'h04
`define OFS_STATUS       8'h08
`define OFS_CAPACITY     8'h0c
`define OFS_FENCE_BASE   8'h10
`define OFS_REGION_BASE  8'h30
`define OFS_STRIDE       8'h04

`define HDR_TYPE_HI      31
`define HDR_TYPE_LO      29
`define HDR_SUBTYPE_HI   28
`define HDR_SUBTYPE_LO   27
`define HDR_OPC_HI       26
`define HDR_OPC_LO       24
`define HDR_SUBOPC_HI    23
`define HDR_SUBOPC_LO    16
`define HDR_ZERO_HI      15
`define HDR_ZERO_LO      14
`define HDR_REQ_HI       13
`define HDR_REQ_LO       9

`define CMD_TYPE_VAL     3'h3
`define CMD_SUBTYPE_VAL  2'h0
`define CMD_OPC_VAL      3'h0
`define CMD_SUBOPC_VAL   8'h00
`define ZERO_FIELD_VAL   2'h0

`define NUM_UNITS        6
`define SLOT_VS          0
`define SLOT_GEOM        1
`define SLOT_TRIM        2
`define SLOT_STRIP       3
`define SLOT_VIDEO       4
`define SLOT_CS          5
`define ACTIVE_3D        6'h2f
`define ACTIVE_MEDIA     6'h30

`define ST_BUSY          0
`define ST_ERR           1
`define ST_CONST         2
`define ST_PIPE          3
`define ST_REQ_LO        8
`define REGION_END_LO    16

`define RST_WORD         32'h0000_0000
`define RST_MASK         6'h00
`define CAPACITY_DEF     1024

`endif

/* common/region_boundary_command_pkg.sv */
// types shared by the region boundary allocator
// assumes the register map header is compiled alongside
package region_boundary_command_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_DECODE = 2'h1,
    ST_APPLY  = 2'h3
  } fsm_state_t;

  typedef enum logic {
    PIPE_3D    = 1'h0,
    PIPE_MEDIA = 1'h1
  } graphics_pipe_type_t;

endpackage

/* core/region_boundary_allocator.sv */
// region boundary command decoder and unified return buffer allocator, apb slave
// assumes apb master on pclk, context_switch and constant_load are one-cycle pulses
// Functional notes
// - all boundaries are pointers counted in 512-bit allocation units.
// - a unit's fence is the first address after its region.
// - a region starts at the previous active unit's fence, ends at its own.
// - the first unit in the order starts at address zero.
// - nothing at or above the command streamer fence is ever allocated.
// - equal fences give a unit no storage; issuer must disable that unit.
// - layout follows the selected pipe; fences of the other pipe are ignored.
// - buffer capacity is 256, 384 or 1024 units per variant.
// - fence changes move boundaries only; stored data is never copied.
// - command is type 3h, subtype 0h, opcode 0h, sub-opcode 00h, bits 15:14 zero.
// - header bit 13 reallocates the command streamer's entries.
// - streamer reallocation invalidates constant entries until reloaded.
// - bits 12..9 reallocate video front, strip fan, trim, geometry stages.
// - context switches reallocate every active unit without a request bit.
// - all selected-pipe fences are applied whether or not reallocation is asked.
`timescale 1ns/1ns
`include "region_boundary_command_regs.svh"

module region_boundary_allocator #(
  parameter int CAPACITY = `CAPACITY_DEF,
  parameter int PTR_W    = $clog2(CAPACITY) + 1
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  input  wire logic                                 context_switch,
  input  wire logic                                 constant_load,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  output logic [`NUM_UNITS-1:0][PTR_W-1:0]          region_start,
  output logic [`NUM_UNITS-1:0][PTR_W-1:0]          region_end,
  output logic [`NUM_UNITS-1:0]                     unit_empty,
  output logic [`NUM_UNITS-1:0]                     realloc_pulse,
  output logic                                      constant_valid,
  output logic [PTR_W-1:0]                          usable_limit
);

  localparam int N = `NUM_UNITS;
  localparam logic [PTR_W-1:0] CAP_PTR = PTR_W'(CAPACITY);

  region_boundary_command_pkg::fsm_state_t           state_reg;
  region_boundary_command_pkg::graphics_pipe_type_t  pipe_reg;
  logic [31:0]                         hdr_reg;
  logic                                cmd_error_reg;
  logic [N-1:0]                        last_req_reg;
  logic [PTR_W-1:0]                    fence_stage [N];
  logic [PTR_W-1:0]                    fence_applied [N];
  logic [PTR_W-1:0]                    chain [N+1];
  logic [PTR_W-1:0]                    end_next [N];
  logic [N-1:0]                        active;
  logic [N-1:0]                        req_mask;
  logic [N-1:0]                        realloc_next;
  logic                                hdr_ok;
  logic                                busy;
  logic                                access;
  logic                                fire;
  logic                                hdr_hit;
  logic                                pready_next;
  logic [31:0]                         rdata_next;
  logic                                err_next;
  logic                                context_switch_q;

  assign busy    = (state_reg != region_boundary_command_pkg::ST_IDLE);
  assign access  = psel && penable;
  assign fire    = access && pready;
  assign hdr_hit = (paddr == `OFS_CMD_HDR);

  // a header write while a command is still in flight is held off, not dropped
  assign pready_next = access && !pready && !(pwrite && hdr_hit && busy);

  assign active = (pipe_reg == region_boundary_command_pkg::PIPE_MEDIA) ? `ACTIVE_MEDIA : `ACTIVE_3D;

  assign hdr_ok = (hdr_reg[`HDR_TYPE_HI:`HDR_TYPE_LO] == `CMD_TYPE_VAL)
               && (hdr_reg[`HDR_SUBTYPE_HI:`HDR_SUBTYPE_LO] == `CMD_SUBTYPE_VAL)
               && (hdr_reg[`HDR_OPC_HI:`HDR_OPC_LO] == `CMD_OPC_VAL)
               && (hdr_reg[`HDR_SUBOPC_HI:`HDR_SUBOPC_LO] == `CMD_SUBOPC_VAL)
               && (hdr_reg[`HDR_ZERO_HI:`HDR_ZERO_LO] == `ZERO_FIELD_VAL);

  assign req_mask = {hdr_reg[`HDR_REQ_HI:`HDR_REQ_LO], 1'b0};

  assign realloc_next = ((state_reg == region_boundary_command_pkg::ST_APPLY) ? (req_mask & active) : `RST_MASK)
                      | (context_switch ? active : `RST_MASK);

  assign chain[0] = '0;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_unit
      // exclusive ends, clamped to capacity and to the region start
      always_comb begin
        end_next[g] = (fence_applied[g] > CAP_PTR) ? CAP_PTR : fence_applied[g];
        if (!active[g] || end_next[g] < chain[g]) begin
          end_next[g] = chain[g];
        end
      end
      assign chain[g+1] = end_next[g];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fence_applied[g] <= '0;
        end else if (state_reg == region_boundary_command_pkg::ST_APPLY && active[g]) begin
          fence_applied[g] <= fence_stage[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fence_stage[g] <= '0;
        end else if (fire && pwrite
                     && paddr == 8'(`OFS_FENCE_BASE + g * `OFS_STRIDE)) begin
          fence_stage[g] <= pwdata[PTR_W-1:0];
        end
      end

      // only boundaries move, no data is touched
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          region_start[g] <= '0;
          region_end[g]   <= '0;
          unit_empty[g]   <= 1'b1;
        end else begin
          region_start[g] <= chain[g];
          region_end[g]   <= end_next[g];
          unit_empty[g]   <= (end_next[g] == chain[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usable_limit <= '0;
    end else begin
      usable_limit <= chain[N];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= region_boundary_command_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        region_boundary_command_pkg::ST_IDLE: begin
          if (fire && pwrite && hdr_hit) begin
            state_reg <= region_boundary_command_pkg::ST_DECODE;
          end
        end
        region_boundary_command_pkg::ST_DECODE: begin
          state_reg <= hdr_ok ? region_boundary_command_pkg::ST_APPLY : region_boundary_command_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= region_boundary_command_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_reg <= `RST_WORD;
    end else if (fire && pwrite && hdr_hit) begin
      hdr_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_error_reg <= 1'b0;
    end else if (state_reg == region_boundary_command_pkg::ST_DECODE) begin
      cmd_error_reg <= !hdr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_reg <= region_boundary_command_pkg::PIPE_3D;
    end else if (fire && pwrite && paddr == `OFS_PIPE_CTRL) begin
      pipe_reg <= region_boundary_command_pkg::graphics_pipe_type_t'(pwdata[0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      realloc_pulse <= `RST_MASK;
      last_req_reg  <= `RST_MASK;
    end else begin
      realloc_pulse <= realloc_next;
      if (realloc_next != `RST_MASK) begin
        last_req_reg <= realloc_next;
      end
    end
  end

  // streamer realloc drops constants; a load in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      constant_valid <= 1'b0;
    end else if (constant_load) begin
      constant_valid <= 1'b1;
    end else if (realloc_next[`SLOT_CS]) begin
      constant_valid <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = `RST_WORD;
    err_next   = 1'b0;
    case (paddr)
      `OFS_CMD_HDR:   rdata_next = hdr_reg;
      `OFS_PIPE_CTRL: rdata_next = {31'h0, pipe_reg};
      `OFS_CAPACITY:  rdata_next = 32'(CAPACITY);
      `OFS_STATUS: begin
        rdata_next[`ST_BUSY]  = busy;
        rdata_next[`ST_ERR]   = cmd_error_reg;
        rdata_next[`ST_CONST] = constant_valid;
        rdata_next[`ST_PIPE]  = pipe_reg;
        rdata_next[`ST_REQ_LO +: N] = last_req_reg;
      end
      default: begin
        err_next = 1'b1;
        for (int i = 0; i < N; i++) begin
          if (paddr == 8'(`OFS_FENCE_BASE + i * `OFS_STRIDE)) begin
            rdata_next = 32'(fence_stage[i]);
            err_next   = 1'b0;
          end
          if (paddr == 8'(`OFS_REGION_BASE + i * `OFS_STRIDE)) begin
            rdata_next[PTR_W-1:0] = region_start[i];
            rdata_next[`REGION_END_LO +: PTR_W] = region_end[i];
            err_next   = pwrite;
          end
        end
      end
    endcase
    if (pwrite && (paddr == `OFS_STATUS || paddr == `OFS_CAPACITY)) begin
      err_next = 1'b1;
    end
  end

  // slave answers on the second access cycle, later only behind a busy header write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready  <= pready_next;
      pslverr <= pready_next && err_next;
      prdata  <= (pready_next && !pwrite) ? rdata_next : `RST_WORD;
    end
  end

  initial begin
    cap_variant_a: assert (CAPACITY == 256 || CAPACITY == 384 || CAPACITY == 1024)
      else $error("capacity is not a supported variant");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hdr_decode_a: assert property (
    state_reg == region_boundary_command_pkg::ST_DECODE && !hdr_ok |=> state_reg == region_boundary_command_pkg::ST_IDLE
      && cmd_error_reg ##1 realloc_pulse[`SLOT_CS] == context_switch_q)
    else $error("bad header was not refused");

  cs_realloc_a: assert property (
    state_reg == region_boundary_command_pkg::ST_APPLY && hdr_reg[`HDR_REQ_HI] |=> realloc_pulse[`SLOT_CS])
    else $error("streamer reallocation missing");

  no_request_a: assert property (
    state_reg == region_boundary_command_pkg::ST_APPLY && !hdr_reg[`HDR_REQ_LO] && !context_switch
      |=> !realloc_pulse[`SLOT_GEOM])
    else $error("geometry realloc without request");

  ctx_switch_a: assert property (
    context_switch |=> (realloc_pulse & $past(active)) == $past(active))
    else $error("context switch did not reallocate");

  first_start_a: assert property (
    pipe_reg == region_boundary_command_pkg::PIPE_MEDIA ##1 pipe_reg == region_boundary_command_pkg::PIPE_MEDIA
      |-> region_start[`SLOT_VIDEO] == '0)
    else $error("first region does not start at zero");

  ignore_fence_a: assert property (
    state_reg == region_boundary_command_pkg::ST_APPLY && pipe_reg == region_boundary_command_pkg::PIPE_MEDIA
      |=> $stable(fence_applied[`SLOT_GEOM]))
    else $error("unselected pipe fence was applied");

  apply_all_a: assert property (
    state_reg == region_boundary_command_pkg::ST_APPLY && pipe_reg == region_boundary_command_pkg::PIPE_3D
      |=> fence_applied[`SLOT_STRIP] == $past(fence_stage[`SLOT_STRIP]))
    else $error("selected fence not applied");

  const_inval_a: assert property (
    realloc_next[`SLOT_CS] && !constant_load |=> !constant_valid)
    else $error("constants survived streamer reallocation");

  contiguous_a: assert property (
    region_start[`SLOT_TRIM] == region_end[`SLOT_GEOM] && region_end[`SLOT_CS] <= CAP_PTR)
    else $error("regions not contiguous or beyond capacity");

  below_limit_a: assert property (
    region_end[`SLOT_CS] == usable_limit
      && region_end[`SLOT_STRIP] <= usable_limit)
    else $error("region beyond streamer fence");

  fence_cmd_c: cover property (state_reg == region_boundary_command_pkg::ST_APPLY && hdr_reg[`HDR_REQ_HI]);
  ctx_switch_c: cover property (context_switch && pipe_reg == region_boundary_command_pkg::PIPE_MEDIA);
  bad_hdr_c: cover property (state_reg == region_boundary_command_pkg::ST_DECODE && !hdr_ok);
  empty_unit_c: cover property (unit_empty[`SLOT_TRIM] && !unit_empty[`SLOT_CS]);

  // switch pulse delayed one cycle, so the refused-header check can allow for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      context_switch_q <= 1'b0;
    end else begin
      context_switch_q <= context_switch;
    end
  end

endmodule

/* sim/pipe_units_model.sv */
// model of the fixed-function units and command streamer behind the allocator
// assumes realloc_pulse is a one-cycle pulse per slot on pclk
`timescale 1ns/1ns
module pipe_units_model (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [5:0]      realloc_pulse,
  input  wire logic            hold,
  output logic                 constant_load,
  output logic [5:0][7:0]      pulse_cnt
);
  logic reload_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (realloc_pulse[i]) begin
          pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
        end
      end
    end
  end

  // constants reloaded
  // hold keeps the reload pending, so the bench can see the invalid window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg    <= 1'b0;
      constant_load <= 1'b0;
    end else begin
      constant_load <= reload_reg & ~hold;
      if (realloc_pulse[5]) begin
        reload_reg <= 1'b1;
      end else if (!hold) begin
        reload_reg <= 1'b0;
      end
    end
  end
endmodule

/* sim/tb.sv */
// self-checking bench of the region boundary allocator
// assumes the unit model in its own file; apb master driven from here
`timescale 1ns/1ns
`include "region_boundary_command_regs.svh"
module tb;
  localparam int CAP = 384;
  localparam int PW  = $clog2(CAP) + 1;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, er, hold = 0, context_switch = 0;
  logic              constant_load, constant_valid;
  logic [5:0][PW-1:0] rs, re;
  logic [5:0]        unit_empty, realloc_pulse;
  logic [PW-1:0]     usable_limit;
  logic [5:0][7:0]   cnt;
  int                err_count = 0, total_checks = 0;

  always #4 pclk = ~pclk;

  region_boundary_allocator #(.CAPACITY(CAP)) region_boundary_allocator_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .context_switch(context_switch),
    .constant_load(constant_load), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .region_start(rs), .region_end(re), .unit_empty(unit_empty),
    .realloc_pulse(realloc_pulse), .constant_valid(constant_valid),
    .usable_limit(usable_limit));

  pipe_units_model pipe_units_model_i (
    .pclk(pclk), .presetn(presetn), .realloc_pulse(realloc_pulse), .hold(hold),
    .constant_load(constant_load), .pulse_cnt(cnt));

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("Error pready expected 1 seen %b", pready);
      err_count++;
      close_out();
    end
    @(posedge pclk);
  endtask

  // full set of six fences, one header
  task automatic cmd(input int f[6], input logic [31:0] h);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'(`OFS_FENCE_BASE + 4 * i), 32'(f[i]));
    end
    apb(1'b1, `OFS_CMD_HDR, h);
    repeat (8) @(posedge pclk);
  endtask

  task automatic reg_chk(input int i, input int s, input int e);
    chk("region_start", 32'(s), 32'(rs[i]));
    chk("region_end", 32'(e), 32'(re[i]));
    chk("unit_empty", 32'(s == e), 32'(unit_empty[i]));
    apb(1'b0, 8'(`OFS_REGION_BASE + 4 * i), 32'h0);
    chk("region_word", (32'(e) << 16) | 32'(s), rd);
  endtask

  task automatic t_reset;
    chk("unit_empty", 32'h3f, 32'(unit_empty));
    chk("constant_valid", 32'h0, 32'(constant_valid));
    chk("usable_limit", 32'h0, 32'(usable_limit));
    apb(1'b0, `OFS_CAPACITY, 32'h0);
    chk("capacity", 32'(CAP), rd);
    $display("test reset done");
  endtask

  task automatic t_3d;
    cmd('{10, 20, 20, 40, 99, 64}, 32'h6000_3e00);
    reg_chk(0, 0, 10);
    reg_chk(1, 10, 20);
    reg_chk(2, 20, 20);
    reg_chk(3, 20, 40);
    reg_chk(4, 40, 40);
    reg_chk(5, 40, 64);
    chk("usable_limit", 32'd64, 32'(usable_limit));
    chk("cnt", 32'h0001_0101, {8'h0, cnt[3], cnt[2], cnt[1]});
    chk("cnt_vs", 32'h0, 32'(cnt[0]));
    chk("cnt_cs", 32'h1, 32'(cnt[5]));
    chk("constant_valid", 32'h1, 32'(constant_valid));
    cmd('{10, 20, 20, 40, 99, 70}, 32'h6000_0000);
    reg_chk(5, 40, 70);
    chk("cnt_cs", 32'h1, 32'(cnt[5]));
    chk("constant_valid", 32'h1, 32'(constant_valid));
    $display("test 3d layout done");
  endtask

  task automatic t_hold;
    hold <= 1'b1;
    cmd('{16, 20, 20, 40, 99, 70}, 32'h6000_2000);
    chk("constant_valid", 32'h0, 32'(constant_valid));
    chk("cnt_cs", 32'h2, 32'(cnt[5]));
    chk("cnt_geom", 32'h1, 32'(cnt[1]));
    reg_chk(0, 0, 16);
    reg_chk(1, 16, 20);
    hold <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("constant_valid", 32'h1, 32'(constant_valid));
    $display("test slow reload done");
  endtask

  task automatic t_bad;
    logic [31:0] bad[5];
    bad = '{32'h4000_0200, 32'h6800_0200, 32'h6100_0200, 32'h6001_0200, 32'h6000_4200};
    foreach (bad[k]) begin
      cmd('{5, 20, 20, 40, 99, 90}, bad[k]);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("cmd_error", 32'h1, 32'(rd[`ST_ERR]));
      chk("usable_limit", 32'd70, 32'(usable_limit));
      chk("cnt_geom", 32'h1, 32'(cnt[1]));
    end
    cmd('{5, 20, 20, 40, 99, 90}, 32'h6000_0000);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("cmd_error", 32'h0, 32'(rd[`ST_ERR]));
    chk("usable_limit", 32'd90, 32'(usable_limit));
    $display("test bad header done");
  endtask

  task automatic t_media;
    apb(1'b1, `OFS_PIPE_CTRL, 32'h1);
    cmd('{1, 2, 3, 4, 30, 50}, 32'h6000_1000);
    reg_chk(4, 0, 30);
    reg_chk(5, 30, 50);
    chk("cnt_video", 32'h1, 32'(cnt[4]));
    context_switch <= 1'b1;
    @(posedge pclk);
    context_switch <= 1'b0;
    @(posedge pclk);
    chk("realloc_pulse", 32'(`ACTIVE_MEDIA), 32'(realloc_pulse));
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status_req", 32'(`ACTIVE_MEDIA), 32'(rd[`ST_REQ_LO +: 6]));
    chk("status_pipe", 32'h1, 32'(rd[`ST_PIPE]));
    $display("test media pipe done");
  endtask

  task automatic t_refuse;
    apb(1'b0, 8'hfc, 32'h0);
    chk("pslverr_unmapped", 32'h1, 32'(er));
    apb(1'b1, `OFS_STATUS, 32'hffff_ffff);
    chk("pslverr_ro", 32'h1, 32'(er));
    apb(1'b1, `OFS_CAPACITY, 32'h0);
    apb(1'b0, `OFS_CAPACITY, 32'h0);
    chk("capacity", 32'(CAP), rd);
    $display("test refused access done");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_3d();
    t_hold();
    t_bad();
    t_media();
    t_refuse();
    close_out();
  end
endmodule
